// ---- src/eeprom_host_map.vh ----
// Constants for the paged EEPROM host controller: opcodes, timings and command sequences
`ifndef EEPROM_HOST_MAP_VH
`define EEPROM_HOST_MAP_VH

// Command opcodes on the user port
`define OP_READ       3'h0
`define OP_PAGE       3'h1
`define OP_LOCK_ON    3'h2
`define OP_LOCK_OFF   3'h3
`define OP_SW_ERASE   3'h4
`define OP_HW_ERASE   3'h5
`define OP_LOCKED_PG  3'h6

// Geometry
`define ADDR_W        15
`define DATA_W        8
`define PAGE_BYTES    64
`define OFF_W         6
`define CNT_W         7
`define ID_PAGE       9'h1FF

// Timing, printed units
`define CLK_NS        20
`define T_WP_NS       100
`define T_WPH_NS      50
`define T_ACC_NS      150
`define T_BLC_US      150
`define T_WC_US       10000
`define T_ER_SH_US    5
`define T_ER_W_US     10000

// Cycle counts derived from the times (all round up except the load window BLC_CYC, which rounds down)
`define WP_CYC        ((`T_WP_NS + `CLK_NS - 1) / `CLK_NS)
`define WPH_CYC       ((`T_WPH_NS + `CLK_NS - 1) / `CLK_NS)
`define ACC_CYC       ((`T_ACC_NS + `CLK_NS - 1) / `CLK_NS)
`define BLC_CYC       ((`T_BLC_US * 1000) / `CLK_NS)
`define WC_CYC        ((`T_WC_US * 1000 + `CLK_NS - 1) / `CLK_NS)
`define ER_SH_CYC     ((`T_ER_SH_US * 1000 + `CLK_NS - 1) / `CLK_NS)
`define ER_W_CYC      ((`T_ER_W_US * 1000 + `CLK_NS - 1) / `CLK_NS)

// Command sequences: entries of {address[14:0], data[7:0]}, entry 0 in the low bits
`define SEQ_ENT_W     23
`define LOCK_ON_LEN   3
`define LOCK_OFF_LEN  6
`define ERASE_LEN     6
`define LOCK_ON_SEQ   69'h0
`define LOCK_OFF_SEQ  138'h0
`define ERASE_SEQ     138'h0

`endif

// ---- src/page_buffer.v ----
// Small page buffer: holds {byte offset, data} entries for one page load
`timescale 1ns/1ps
`default_nettype none
module page_buffer #(
	parameter WIDTH = 14,
	parameter DEPTH = 64,
	parameter AW    = 6
) (
	input  wire             clk,      // System clock
	input  wire             wr_en,    // Write strobe
	input  wire [AW-1:0]    wr_addr,  // Write index
	input  wire [WIDTH-1:0] wr_data,  // Write entry
	input  wire [AW-1:0]    rd_addr,  // Read index
	output reg  [WIDTH-1:0] rd_data   // Registered read entry
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];

	always @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end
endmodule // page_buffer
`default_nettype wire

// ---- src/eeprom_host.v ----
// Host controller that drives a paged byte-wide EEPROM through its strobe, address and data pins
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_host_map.vh"
module eeprom_host #(
	parameter [19:0]                       WC_CYC       = `WC_CYC,
	parameter [19:0]                       ER_SH_CYC    = `ER_SH_CYC,
	parameter [19:0]                       ER_W_CYC     = `ER_W_CYC,
	parameter [`LOCK_ON_LEN*`SEQ_ENT_W-1:0]  LOCK_ON_SEQ  = `LOCK_ON_SEQ,
	parameter [`LOCK_OFF_LEN*`SEQ_ENT_W-1:0] LOCK_OFF_SEQ = `LOCK_OFF_SEQ,
	parameter [`ERASE_LEN*`SEQ_ENT_W-1:0]    ERASE_SEQ    = `ERASE_SEQ
) (
	input  wire               clk,          // 50 MHz clock
	input  wire               rst_n,        // Asynchronous reset, active low
	input  wire               cmd_valid,    // Command request
	input  wire [2:0]         cmd_op,       // Command opcode
	input  wire [`ADDR_W-1:0] cmd_addr,     // Read address or page address
	input  wire [`CNT_W-1:0]  cmd_count,    // Page bytes to write, 0 to 64
	input  wire               cmd_id,       // Target identification area
	input  wire               buf_wr_en,    // Page buffer write strobe
	input  wire [`OFF_W-1:0]  buf_wr_idx,   // Page buffer entry index
	input  wire [`OFF_W-1:0]  buf_wr_off,   // Byte offset within page
	input  wire [`DATA_W-1:0] buf_wr_data,  // Byte to program
	output reg                busy_q,       // Command in progress
	output reg                done_q,       // One-cycle completion pulse
	output reg  [`DATA_W-1:0] rd_data_q,    // Read result
	output reg  [`ADDR_W-1:0] addr_q,       // Address pins
	output reg                ce_n_q,       // Select strobe, active low
	output reg                oe_n_q,       // Output-drive control, active low
	output reg                we_n_q,       // Write strobe, active low
	output reg                oe_hv_q,      // Request elevated level on output-drive
	output reg                id_sel_q,     // Request elevated level on address_line_nine
	output reg  [`DATA_W-1:0] dq_out_q,     // Data pins, output
	output reg                dq_oe_q,      // Data pins, output enable
	input  wire [`DATA_W-1:0] dq_in         // Data pins, input
);
	localparam [3:0] S_IDLE   = 4'h0;
	localparam [3:0] S_LOAD   = 4'h1;
	localparam [3:0] S_SETUP  = 4'h2;
	localparam [3:0] S_LOW    = 4'h3;
	localparam [3:0] S_HIGH   = 4'h4;
	localparam [3:0] S_TWC    = 4'h5;
	localparam [3:0] S_READ   = 4'h6;
	localparam [3:0] S_ER_SU  = 4'h7;
	localparam [3:0] S_ER_W   = 4'h8;
	localparam [3:0] S_ER_H   = 4'h9;

	localparam [19:0] WP_C  = `WP_CYC;
	localparam [19:0] WPH_C = `WPH_CYC;
	localparam [19:0] ACC_C = `ACC_CYC;
	localparam [2:0]  ON_L  = `LOCK_ON_LEN;
	localparam [2:0]  OFF_L = `LOCK_OFF_LEN;
	localparam [2:0]  ER_L  = `ERASE_LEN;

	reg [3:0]         state_q;
	reg [19:0]        cnt_q;
	reg [2:0]         op_q;
	reg [8:0]         page_q;
	reg [`CNT_W-1:0]  count_q;
	reg               id_q;
	reg               phase_q;   // 0 sequence bytes, 1 page data bytes
	reg [2:0]         seq_k_q;
	reg [`OFF_W-1:0]  idx_q;

	wire [`OFF_W+`DATA_W-1:0] buf_rd;

	page_buffer #(
		.WIDTH (`OFF_W + `DATA_W),
		.DEPTH (`PAGE_BYTES),
		.AW    (`OFF_W)
	) u_buf (
		.clk     (clk),
		.wr_en   (buf_wr_en),
		.wr_addr (buf_wr_idx),
		.wr_data ({buf_wr_off, buf_wr_data}),
		.rd_addr (idx_q),
		.rd_data (buf_rd)
	);

	// Sequence entry for the current command
	function [`SEQ_ENT_W-1:0] seq_entry;
		input [2:0] op;
		input [2:0] k;
		begin
			case (op)
				`OP_LOCK_ON, `OP_LOCKED_PG: seq_entry = LOCK_ON_SEQ[k*`SEQ_ENT_W +: `SEQ_ENT_W];
				`OP_LOCK_OFF: seq_entry = LOCK_OFF_SEQ[k*`SEQ_ENT_W +: `SEQ_ENT_W];
				`OP_SW_ERASE: seq_entry = ERASE_SEQ[k*`SEQ_ENT_W +: `SEQ_ENT_W];
				default:      seq_entry = {`SEQ_ENT_W{1'b0}};
			endcase
		end
	endfunction

	function [2:0] seq_len;
		input [2:0] op;
		begin
			case (op)
				`OP_LOCK_ON, `OP_LOCKED_PG: seq_len = ON_L;
				`OP_LOCK_OFF: seq_len = OFF_L;
				`OP_SW_ERASE: seq_len = ER_L;
				default:      seq_len = 3'h0;
			endcase
		end
	endfunction

	wire [`SEQ_ENT_W-1:0] seq_now = seq_entry(op_q, seq_k_q);
	// Page bits fixed per command, so every data-byte strobe of a load shares them; sequence bytes use their own
	wire [`ADDR_W-1:0]    dat_addr = {page_q, buf_rd[`OFF_W+`DATA_W-1:`DATA_W]};
	wire                  more_seq = (seq_k_q + 3'h1) < seq_len(op_q);
	wire                  more_dat = ({1'b0, idx_q} + 7'h01) < count_q;
	wire                  has_dat  = (op_q == `OP_PAGE) || (op_q == `OP_LOCK_ON) ||
	                                 (op_q == `OP_LOCKED_PG);

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q   <= S_IDLE;
			cnt_q     <= 20'h00000;
			op_q      <= 3'h0;
			page_q    <= 9'h000;
			count_q   <= 7'h00;
			id_q      <= 1'b0;
			phase_q   <= 1'b0;
			seq_k_q   <= 3'h0;
			idx_q     <= 6'h00;
			busy_q    <= 1'b0;
			done_q    <= 1'b0;
			rd_data_q <= 8'h00;
			addr_q    <= 15'h0000;
			ce_n_q    <= 1'b1;
			oe_n_q    <= 1'b1;
			we_n_q    <= 1'b1;
			oe_hv_q   <= 1'b0;
			id_sel_q  <= 1'b0;
			dq_out_q  <= 8'h00;
			dq_oe_q   <= 1'b0;
		end else begin
			done_q <= 1'b0;
			case (state_q)
				S_IDLE: begin
					if (cmd_valid && !busy_q) begin
						busy_q  <= 1'b1;
						op_q    <= cmd_op;
						id_q    <= cmd_id;
						id_sel_q <= cmd_id;
						// The identification area is the top page
						page_q  <= cmd_id ? `ID_PAGE : cmd_addr[14:6];
						count_q <= (cmd_count > 7'h40) ? 7'h40 : cmd_count;
						seq_k_q <= 3'h0;
						idx_q   <= 6'h00;
						case (cmd_op)
							`OP_READ: begin
								addr_q  <= cmd_id ? {`ID_PAGE, cmd_addr[5:0]} : cmd_addr;
								ce_n_q  <= 1'b0;
								oe_n_q  <= 1'b0;
								cnt_q   <= ACC_C;
								state_q <= S_READ;
							end
							`OP_PAGE: begin
								phase_q <= 1'b1;
								if (cmd_count == 7'h00) begin
									busy_q  <= 1'b0;
									done_q  <= 1'b1;
									id_sel_q <= 1'b0;
								end else begin
									state_q <= S_LOAD;
								end
							end
							`OP_HW_ERASE: begin
								ce_n_q  <= 1'b0;
								oe_hv_q <= 1'b1;
								cnt_q   <= ER_SH_CYC;
								state_q <= S_ER_SU;
							end
							`OP_LOCK_ON, `OP_LOCK_OFF, `OP_SW_ERASE, `OP_LOCKED_PG: begin
								phase_q <= 1'b0;
								state_q <= S_SETUP;
							end
							default: begin
								busy_q   <= 1'b0;
								done_q   <= 1'b1;
								id_sel_q <= 1'b0;
							end
						endcase
					end
				end
				S_LOAD: begin
					// Buffer read data is registered, one cycle here
					state_q <= S_SETUP;
				end
				S_SETUP: begin
					if (phase_q) begin
						addr_q   <= dat_addr;
						dq_out_q <= buf_rd[`DATA_W-1:0];
					end else begin
						addr_q   <= seq_now[`SEQ_ENT_W-1:`DATA_W];
						dq_out_q <= seq_now[`DATA_W-1:0];
					end
					dq_oe_q <= 1'b1;
					oe_n_q  <= 1'b1;
					ce_n_q  <= 1'b0;
					cnt_q   <= WP_C;
					state_q <= S_LOW;
				end
				S_LOW: begin
					// Output-drive is high here, so the device latches the write
					we_n_q <= 1'b0;
					if (cnt_q == 20'h00001) begin
						cnt_q   <= WPH_C;
						state_q <= S_HIGH;
					end else begin
						cnt_q <= cnt_q - 20'h00001;
					end
				end
				S_HIGH: begin
					we_n_q <= 1'b1;
					ce_n_q <= 1'b1;
					if (cnt_q == 20'h00001) begin
						dq_oe_q <= 1'b0;
						// Bytes follow in a few cycles, far inside the load window
						if (!phase_q && more_seq) begin
							seq_k_q <= seq_k_q + 3'h1;
							state_q <= S_SETUP;
						end else if (!phase_q && has_dat && count_q != 7'h00) begin
							phase_q <= 1'b1;
							state_q <= S_LOAD;
						end else if (phase_q && more_dat) begin
							idx_q   <= idx_q + 6'h01;
							state_q <= S_LOAD;
						end else begin
							// Device closes the load by timeout, lock state moves then
							cnt_q   <= WC_CYC;
							state_q <= S_TWC;
						end
					end else begin
						cnt_q <= cnt_q - 20'h00001;
					end
				end
				S_TWC: begin
					// No polling: the full worst-case period is spent idle
					if (cnt_q == 20'h00001) begin
						id_sel_q <= 1'b0;
						busy_q   <= 1'b0;
						done_q   <= 1'b1;
						state_q  <= S_IDLE;
					end else begin
						cnt_q <= cnt_q - 20'h00001;
					end
				end
				S_READ: begin
					if (cnt_q == 20'h00001) begin
						rd_data_q <= dq_in;
						ce_n_q    <= 1'b1;
						oe_n_q    <= 1'b1;
						id_sel_q  <= 1'b0;
						busy_q    <= 1'b0;
						done_q    <= 1'b1;
						state_q   <= S_IDLE;
					end else begin
						cnt_q <= cnt_q - 20'h00001;
					end
				end
				S_ER_SU: begin
					if (cnt_q == 20'h00001) begin
						we_n_q  <= 1'b0;
						cnt_q   <= ER_W_CYC;
						state_q <= S_ER_W;
					end else begin
						cnt_q <= cnt_q - 20'h00001;
					end
				end
				S_ER_W: begin
					if (cnt_q == 20'h00001) begin
						we_n_q  <= 1'b1;
						cnt_q   <= ER_SH_CYC;
						state_q <= S_ER_H;
					end else begin
						cnt_q <= cnt_q - 20'h00001;
					end
				end
				S_ER_H: begin
					if (cnt_q == 20'h00001) begin
						ce_n_q   <= 1'b1;
						oe_hv_q  <= 1'b0;
						id_sel_q <= 1'b0;
						busy_q   <= 1'b0;
						done_q   <= 1'b1;
						state_q  <= S_IDLE;
					end else begin
						cnt_q <= cnt_q - 20'h00001;
					end
				end
				default: begin
					state_q <= S_IDLE;
				end
			endcase
		end
	end
endmodule // eeprom_host
`default_nettype wire

// ---- test/eeprom_host_monitor.sv ----
// Pin and command timing checker for the paged EEPROM host controller
`timescale 1ns/1ps
`default_nettype none
module eeprom_host_monitor (
	input wire logic        clk,       // Clock
	input wire logic        rst_n,     // Reset, active low
	input wire logic        cmd_valid, // Request
	input wire logic [2:0]  cmd_op,    // Opcode
	input wire logic [14:0] cmd_addr,  // Address
	input wire logic [6:0]  cmd_count, // Byte count
	input wire logic        cmd_id,    // Id area
	input wire logic        busy_q,    // Busy
	input wire logic        done_q,    // Done pulse
	input wire logic [14:0] addr_q,    // Address pins
	input wire logic        ce_n_q,    // Select
	input wire logic        oe_n_q,    // Output drive
	input wire logic        we_n_q,    // Write strobe
	input wire logic        oe_hv_q,   // Elevated output drive
	input wire logic        id_sel_q,  // Elevated line nine
	input wire logic        dq_oe_q    // Data enable
);
	logic       take;
	logic [8:0] pg_q;
	logic       pg_op_q;
	assign take = cmd_valid && !busy_q;
	// Page captured at take: sequence bytes of other ops use other addresses
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pg_q <= 9'h000;
			pg_op_q <= 1'b0;
		end else if (take) begin
			pg_q <= cmd_id ? 9'h1FF : cmd_addr[14:6];
			pg_op_q <= (cmd_op == 3'h1);
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_write_oe_high: assert property (!we_n_q && !ce_n_q |-> oe_n_q)
		else $error("output drive low during write");
	a_page_same: assert property ($fell(we_n_q) && pg_op_q && busy_q |-> addr_q[14:6] == pg_q)
		else $error("page address changed");
	a_id_level: assert property ($rose(busy_q) |-> id_sel_q == $past(cmd_id))
		else $error("line nine level wrong");
	a_id_page: assert property (id_sel_q && pg_op_q && !we_n_q |-> addr_q[14:6] == 9'h1FF)
		else $error("id write outside top page");
	a_read_done: assert property (take && cmd_op == 3'h0 |-> ##9 done_q)
		else $error("read latency wrong");
	a_read_no_drive: assert property (!oe_n_q |-> !dq_oe_q && we_n_q)
		else $error("contention on data lines");
	a_pulse_width: assert property ($fell(we_n_q) && !oe_hv_q |->
		(!we_n_q && !ce_n_q && oe_n_q && dq_oe_q)[*5] ##1 we_n_q)
		else $error("write pulse wrong");
	a_gap_high: assert property ($rose(we_n_q) && !oe_hv_q |-> we_n_q[*3])
		else $error("strobe high time short");
	a_erase_hv: assert property (oe_hv_q |-> oe_n_q && !dq_oe_q)
		else $error("erase drive wrong");
	a_empty_page: assert property (take && cmd_op == 3'h1 && cmd_count == 7'h00 |=> done_q)
		else $error("empty page not immediate");
	a_done_pulse: assert property (done_q |-> !busy_q ##1 !done_q)
		else $error("done not a pulse");
endmodule // eeprom_host_monitor
bind eeprom_host eeprom_host_monitor u_mon (.clk, .rst_n, .cmd_valid, .cmd_op, .cmd_addr,
	.cmd_count, .cmd_id, .busy_q, .done_q, .addr_q, .ce_n_q, .oe_n_q, .we_n_q, .oe_hv_q,
	.id_sel_q, .dq_oe_q);
`default_nettype wire

// ---- test/eeprom_dev_model.sv ----
// Behavioural model of the paged EEPROM seen at the host controller pins
`timescale 1ns/1ps
`default_nettype none
module eeprom_dev_model (
	input wire logic        ce_n,   // Select
	input wire logic        oe_n,   // Output drive
	input wire logic        we_n,   // Write strobe
	input wire logic        oe_hv,  // Elevated output drive
	input wire logic        id_sel, // Elevated line nine
	input wire logic [14:0] addr,   // Address
	input wire logic [7:0]  dq_out, // Host data
	input wire logic        dq_oe,  // Host drives data
	output logic     [7:0]  dq_in   // Resolved data lines
);
	logic [7:0]  mem [0:32767];
	logic [7:0]  idm [0:63];
	logic [7:0]  rd, last, d_l;
	logic [14:0] a_l;
	logic        ok_l, er_l, id_l;
	logic        drv;
	initial begin
		for (int i = 0; i < 32768; i++) mem[i] = 8'hFF;
		for (int i = 0; i < 64; i++) idm[i] = 8'hFF;
		last = 8'h00;
	end
	assign drv = !ce_n && !oe_n && we_n;
	assign rd = id_sel ? idm[addr[5:0]] : mem[addr];
	// Released lines show the inverse of the last value so a stale read cannot match
	assign dq_in = drv ? rd : (dq_oe ? dq_out : ~last);
	always @* if (drv) last = rd;
	always @(negedge we_n) begin
		a_l = addr;
		d_l = dq_out;
		id_l = id_sel;
		ok_l = !ce_n && oe_n && dq_oe && !oe_hv;
		er_l = !ce_n && oe_hv;
	end
	always @(posedge we_n) begin
		if (er_l) for (int i = 0; i < 32768; i++) mem[i] = 8'hFF;
		else if (ok_l && id_l) idm[a_l[5:0]] = d_l;
		else if (ok_l) mem[a_l] = d_l;
	end
endmodule // eeprom_dev_model
`default_nettype wire

// ---- test/test_eeprom_host.sv ----
// Self-checking bench for the paged EEPROM host controller
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_host_map.vh"
module test_eeprom_host;
	logic        clk = 0, rst_n = 0, cmd_valid = 0, cmd_id = 0, buf_wr_en = 0;
	logic [2:0]  cmd_op = 0;
	logic [14:0] cmd_addr = 0;
	logic [6:0]  cmd_count = 0;
	logic [5:0]  buf_wr_idx = 0, buf_wr_off = 0;
	logic [7:0]  buf_wr_data = 0;
	wire  [7:0]  rd_data_q, dq_out_q, dq_in;
	wire  [14:0] addr_q;
	wire         busy_q, done_q, ce_n_q, oe_n_q, we_n_q, oe_hv_q, id_sel_q, dq_oe_q;
	int          n_fail = 0, checked = 0, cycles = 0, c;
	// Short write and erase periods keep the run small
	localparam logic [19:0] WC_SIM = 20'h00014, ER_SH_SIM = 20'h0000A, ER_W_SIM = 20'h00014;
	// Cycles per strobed byte; data bytes add one buffer read cycle
	localparam int SEQ_B = 1 + `WP_CYC + `WPH_CYC;
	localparam int DAT_B = SEQ_B + 1;
	// Rows of {id, address, expected byte}
	logic [23:0] rows [0:5] = '{{1'b0, 15'h04BF, 8'hA5}, {1'b0, 15'h0480, 8'h3C},
		{1'b0, 15'h0485, 8'h81}, {1'b0, 15'h0481, 8'hFF}, {1'b1, 15'h0001, 8'h5A},
		{1'b0, 15'h7FC1, 8'hFF}};
	logic [2:0]  ops [0:4] = '{3'h2, 3'h3, 3'h4, 3'h6, 3'h7};
	// Sequence bytes then the full write period; the no-op answers at once
	int          op_cyc [0:4] = '{`LOCK_ON_LEN * SEQ_B + WC_SIM, `LOCK_OFF_LEN * SEQ_B + WC_SIM,
		`ERASE_LEN * SEQ_B + WC_SIM, `LOCK_ON_LEN * SEQ_B + WC_SIM, 0};
	eeprom_host #(.WC_CYC(WC_SIM), .ER_SH_CYC(ER_SH_SIM), .ER_W_CYC(ER_W_SIM)) u_dut (
		.clk, .rst_n, .cmd_valid, .cmd_op, .cmd_addr, .cmd_count, .cmd_id, .buf_wr_en,
		.buf_wr_idx,
		.buf_wr_off, .buf_wr_data, .busy_q, .done_q, .rd_data_q, .addr_q, .ce_n_q, .oe_n_q,
		.we_n_q, .oe_hv_q, .id_sel_q, .dq_out_q, .dq_oe_q, .dq_in);
	eeprom_dev_model u_dev (.ce_n(ce_n_q), .oe_n(oe_n_q), .we_n(we_n_q), .oe_hv(oe_hv_q),
		.id_sel(id_sel_q), .addr(addr_q), .dq_out(dq_out_q), .dq_oe(dq_oe_q), .dq_in(dq_in));
	always #10 clk = ~clk;
	task automatic wrap_up();
		$display("compares %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			n_fail++;
			wrap_up();
		end
	end
	task automatic chk(input [31:0] got, input [31:0] exp, input string m);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("Error %0t: %0s got %0h exp %0h", $time, m, got, exp);
		end
	endtask
	task automatic ld(input [5:0] i, input [5:0] off, input [7:0] d);
		@(posedge clk);
		buf_wr_en <= 1;
		buf_wr_idx <= i;
		buf_wr_off <= off;
		buf_wr_data <= d;
		@(posedge clk);
		buf_wr_en <= 0;
	endtask
	// Returns edges from take to the done pulse; 2000 means it never came
	task automatic run(input [2:0] op, input [14:0] a, input [6:0] n, input id, output int cyc);
		@(posedge clk);
		cmd_valid <= 1;
		cmd_op <= op;
		cmd_addr <= a;
		cmd_count <= n;
		cmd_id <= id;
		@(posedge clk);
		cmd_valid <= 0;
		#1;
		cyc = 0;
		while (done_q !== 1'b1 && cyc < 2000) begin
			@(posedge clk);
			#1;
			cyc++;
		end
	endtask
	initial begin
		repeat (3) @(posedge clk);
		chk({ce_n_q, oe_n_q, we_n_q, busy_q, dq_oe_q}, 5'b11100, "reset pins");
		rst_n <= 1;
		ld(6'd0, 6'h3F, 8'hA5);
		ld(6'd1, 6'h00, 8'h3C);
		ld(6'd2, 6'h05, 8'h81);
		run(`OP_PAGE, 15'h0480, 7'd3, 1'b0, c);
		chk(c, 3 * DAT_B + WC_SIM, "page write");
		ld(6'd0, 6'h01, 8'h5A);
		run(`OP_PAGE, 15'h0000, 7'd1, 1'b1, c);
		chk(c, DAT_B + WC_SIM, "id page write");
		run(`OP_PAGE, 15'h0000, 7'd0, 1'b0, c);
		chk(c, 0, "empty page");
		$display("test writes done");
		for (int r = 0; r < 6; r++) begin
			run(`OP_READ, rows[r][22:8], 7'd0, rows[r][23], c);
			chk(rd_data_q, rows[r][7:0], "read data");
			chk(c, `ACC_CYC, "read time");
		end
		$display("test reads done");
		for (int k = 0; k < 5; k++) begin
			run(ops[k], 15'h0000, 7'd0, 1'b0, c);
			chk(c, op_cyc[k], "op time");
		end
		$display("test commands done");
		run(`OP_HW_ERASE, 15'h0000, 7'd0, 1'b0, c);
		chk(c, 2 * ER_SH_SIM + ER_W_SIM, "erase time");
		run(`OP_READ, 15'h04BF, 7'd0, 1'b0, c);
		chk(rd_data_q, 8'hFF, "after erase");
		$display("test erase done");
		// Reset lands in the setup cycle (S_SETUP), before any strobe falls
		@(posedge clk);
		cmd_valid <= 1;
		cmd_op <= `OP_PAGE;
		cmd_addr <= 15'h0480;
		cmd_count <= 7'd1;
		@(posedge clk);
		cmd_valid <= 0;
		@(posedge clk);
		rst_n <= 0;
		@(posedge clk);
		#1;
		chk({ce_n_q, oe_n_q, we_n_q, busy_q, dq_oe_q, done_q}, 6'b111000, "mid reset pins");
		@(posedge clk);
		rst_n <= 1;
		run(`OP_READ, 15'h04BF, 7'd0, 1'b0, c);
		chk(rd_data_q, 8'hFF, "read after reset");
		chk(c, `ACC_CYC, "read time after reset");
		$display("test reset done");
		wrap_up();
	end
endmodule // test_eeprom_host
`default_nettype wire
